//--- pmcg_pkg.sv
package pmcg_pkg;

    // ---------------------------------------------------------------------
    // register map, word addresses on the plain register port
    // ---------------------------------------------------------------------
    localparam logic [3:0] ADDR_MODE_CTRL  = 4'h0; // power mode control
    localparam logic [3:0] ADDR_SLOW_DIV   = 4'h1; // slow-down divider
    localparam logic [3:0] ADDR_SLEEP_CFG  = 4'h2; // sleep options
    localparam logic [3:0] ADDR_PERI_GATE  = 4'h3; // peripheral clock gates
    localparam logic [3:0] ADDR_STATUS     = 4'h4; // mode state, read only

    // ---------------------------------------------------------------------
    // field positions
    // ---------------------------------------------------------------------
    localparam int MODE_SLOW_BIT      = 0;  // slow-down enable
    localparam int MODE_SLEEP_BIT     = 1;  // sleep request, self clearing
    localparam int MODE_PLL_BIT       = 2;  // pll enable
    localparam int MODE_PORT_OFF_BIT  = 3;  // ports off in full stop
    localparam int SLEEP_ALL_BIT      = 0;  // 1: stop whole clock system
    localparam int SLEEP_WAKE_LSB     = 1;  // wake source enables, 5 bits
    localparam int DIV_W              = 5;  // divider field, value+1

    // ---------------------------------------------------------------------
    // reset values
    // ---------------------------------------------------------------------
    localparam logic [3:0]  RST_MODE_CTRL = 4'h4;   // pll on, running
    localparam logic [4:0]  RST_SLOW_DIV  = 5'h00;  // divide by one
    localparam logic [5:0]  RST_SLEEP_CFG = 6'h3E;  // all wake sources
    localparam int          DEF_NPERI     = 8;

    // ---------------------------------------------------------------------
    // power modes
    // ---------------------------------------------------------------------
    typedef enum logic [2:0] {
        PMCG_RUN   = 3'b000,
        PMCG_SLOW  = 3'b001,
        PMCG_IDLE  = 3'b010,
        PMCG_SLEEP = 3'b011,
        PMCG_DOWN  = 3'b100
    } pmcg_mode_t;

endpackage : pmcg_pkg

//--- pmcg_clk_gate.sv
`timescale 1ns/1ps
// ---------------------------------------------------------------------------
// glitch-free clock gate: enable captured on the falling edge so the gated
// clock only changes on the edges of the source
// ---------------------------------------------------------------------------
module pmcg_clk_gate
(
    input  wire logic clk_i,     // source clock
    input  wire logic rst_n_i,   // async reset, active low
    input  wire logic en_i,      // enable from rising-edge logic
    output wire logic gclk_o     // gated clock
);
    logic en_lat; // enable held through the high phase

    // latch on the low phase so no shortened pulse escapes
    always_ff @(negedge clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
            en_lat <= 1'b0;
        else
            en_lat <= en_i; // see [RULE9]
    end

    assign gclk_o = clk_i & en_lat;
endmodule : pmcg_clk_gate

//--- pmcg_top.sv
`timescale 1ns/1ps
// Contract
// [RULE1] slow-down divides cpu clock by 1..32
// [RULE2] idle instruction enters idle mode
// [RULE3] idle keeps peripheral clocks unless gated
// [RULE4] any interrupt or reset leaves idle
// [RULE5] sleep stops most clocks or all
// [RULE6] sleep wakes on selected event sources
// [RULE7] full stop halts all; only reset exits
// [RULE8] per-peripheral clock enables and pll switch
// [RULE9] gating changes only on clock edges
module pmcg_top
#(
    parameter int NPERI = pmcg_pkg::DEF_NPERI  // gated peripherals
)
(
    input  wire logic             SYS_CLK_I,       // 40 MHz source clock
    input  wire logic             RESET_N_I,       // async reset, active low
    input  wire logic             CLK_EN_I,        // freezes state when low
    input  wire logic [3:0]       REG_ADDR_I,      // register address
    input  wire logic [7:0]       REG_WDATA_I,     // write data
    input  wire logic             REG_WR_I,        // write strobe
    input  wire logic             REG_RD_I,        // read strobe
    output wire logic [7:0]       REG_RDATA_O,     // read data, next cycle
    input  wire logic             IDLE_INSTR_I,    // idle instruction pulse
    input  wire logic             STOP_INSTR_I,    // full stop instr pulse
    input  wire logic             IRQ_I,           // any interrupt request
    input  wire logic             EXT_IRQ_I,       // enabled ext interrupt pin
    input  wire logic             NMI_I,           // non-maskable pin
    input  wire logic             RTC_EVT_I,       // rtc event, async mode
    input  wire logic             ETC_REQ_I,       // event transfer request
    input  wire logic             SER_ACT_I,       // serial port activity
    output wire logic             CPU_CLK_O,       // gated cpu clock
    output wire logic             CPU_CLK_EN_O,    // cpu advance enable
    output wire logic [NPERI-1:0] PERI_CLK_O,      // peripheral clocks
    output wire logic             RTC_CLK_O,       // rtc clock
    output wire logic             PLL_EN_O,        // pll on
    output wire logic             PORT_EN_O,       // port drivers on
    output wire logic [2:0]       MODE_O           // current power mode
);
    // -----------------------------------------------------------------------
    // elaboration checks
    // -----------------------------------------------------------------------
    if (NPERI < 1 || NPERI > 8)
    begin : g_bad_nperi
        $error("NPERI must be 1 to 8");
    end

    // -----------------------------------------------------------------------
    // state
    // -----------------------------------------------------------------------
    typedef struct packed {
        pmcg_pkg::pmcg_mode_t mode;     // current power mode
        logic                 slow_en;  // slow-down selected
        logic                 pll_en;   // pll on
        logic                 port_off; // ports off in full stop
        logic [4:0]           div;      // divider value minus one
        logic [5:0]           sleep_cfg;// all-stop bit and wake enables
        logic [7:0]           gates;    // peripheral clock enables
        logic [4:0]           div_cnt;  // divider phase counter
        logic                 cpu_en;   // cpu clock enable
        logic                 rtc_en;   // rtc clock enable
        logic [7:0]           peri_en;  // peripheral clock enables
        logic [4:0]           sync1;    // first synchroniser stage
        logic [4:0]           sync2;    // second synchroniser stage
        logic [7:0]           rdata;    // read data register
    } pmcg_state_t;

    pmcg_state_t st;      // registered state
    pmcg_state_t next_st; // next value

    // wake pin order: ext, nmi, rtc, etc, serial
    logic [4:0] wake_pins;
    assign wake_pins = {SER_ACT_I, ETC_REQ_I, RTC_EVT_I, NMI_I, EXT_IRQ_I};

    // -----------------------------------------------------------------------
    // next-state logic
    // -----------------------------------------------------------------------
    always_comb
    begin
        logic wake_sleep;   // an enabled sleep wake source fired
        logic [7:0] rd;     // read mux
        next_st    = st;
        wake_sleep = 1'b0;
        rd         = 8'h00;

        // wake pins from outside pass two flops before use
        next_st.sync1 = wake_pins;
        next_st.sync2 = st.sync1;
        wake_sleep = |(st.sync2 &
            st.sleep_cfg[pmcg_pkg::SLEEP_WAKE_LSB +: 5]); // see [RULE6]

        // register writes
        if (REG_WR_I)
        begin
            unique case (REG_ADDR_I)
                pmcg_pkg::ADDR_MODE_CTRL:
                begin
                    next_st.slow_en  = REG_WDATA_I[pmcg_pkg::MODE_SLOW_BIT];
                    next_st.pll_en   = REG_WDATA_I[pmcg_pkg::MODE_PLL_BIT];
                    next_st.port_off =
                        REG_WDATA_I[pmcg_pkg::MODE_PORT_OFF_BIT];
                    // sleep request enters from run or slow only
                    if (REG_WDATA_I[pmcg_pkg::MODE_SLEEP_BIT] &&
                        (st.mode == pmcg_pkg::PMCG_RUN ||
                         st.mode == pmcg_pkg::PMCG_SLOW))
                        next_st.mode = pmcg_pkg::PMCG_SLEEP; // see [RULE5]
                end
                pmcg_pkg::ADDR_SLOW_DIV:
                    next_st.div = REG_WDATA_I[pmcg_pkg::DIV_W-1:0];
                pmcg_pkg::ADDR_SLEEP_CFG:
                    next_st.sleep_cfg = REG_WDATA_I[5:0];
                pmcg_pkg::ADDR_PERI_GATE:
                    next_st.gates = REG_WDATA_I; // see [RULE8]
                default:
                    ; // unmapped and read-only addresses ignore writes
            endcase
        end

        // mode sequencing; a write that set sleep may be overridden below
        unique case (st.mode)
            pmcg_pkg::PMCG_RUN,
            pmcg_pkg::PMCG_SLOW:
            begin
                if (STOP_INSTR_I)
                    next_st.mode = pmcg_pkg::PMCG_DOWN; // see [RULE7]
                else if (IDLE_INSTR_I)
                    next_st.mode = pmcg_pkg::PMCG_IDLE; // see [RULE2]
                else if (next_st.mode != pmcg_pkg::PMCG_SLEEP)
                    next_st.mode = next_st.slow_en ? pmcg_pkg::PMCG_SLOW
                                                   : pmcg_pkg::PMCG_RUN;
            end
            pmcg_pkg::PMCG_IDLE:
                if (IRQ_I || wake_sleep) // see [RULE4]
                    next_st.mode = st.slow_en ? pmcg_pkg::PMCG_SLOW
                                              : pmcg_pkg::PMCG_RUN;
            pmcg_pkg::PMCG_SLEEP:
                if (wake_sleep) // see [RULE6]
                    next_st.mode = st.slow_en ? pmcg_pkg::PMCG_SLOW
                                              : pmcg_pkg::PMCG_RUN;
            pmcg_pkg::PMCG_DOWN:
                next_st.mode = pmcg_pkg::PMCG_DOWN; // see [RULE7]
            default:
                next_st.mode = pmcg_pkg::PMCG_RUN;
        endcase

        // divider: cpu enable is high one cycle in div+1 in slow mode
        if (st.div_cnt >= st.div)
            next_st.div_cnt = 5'h00;
        else
            next_st.div_cnt = st.div_cnt + 5'h01;

        // enables computed for the next mode so the gate sees them early
        unique case (next_st.mode)
            pmcg_pkg::PMCG_RUN:
            begin
                next_st.cpu_en  = 1'b1;
                next_st.peri_en = next_st.gates;
                next_st.rtc_en  = 1'b1;
            end
            pmcg_pkg::PMCG_SLOW:
            begin
                next_st.cpu_en  = (next_st.div_cnt == 5'h00); // see [RULE1]
                next_st.peri_en = next_st.gates;
                next_st.rtc_en  = 1'b1;
            end
            pmcg_pkg::PMCG_IDLE:
            begin
                next_st.cpu_en  = 1'b0;
                next_st.peri_en = next_st.gates; // see [RULE3]
                next_st.rtc_en  = 1'b1;
            end
            pmcg_pkg::PMCG_SLEEP:
            begin
                next_st.cpu_en  = 1'b0;
                next_st.peri_en = 8'h00;
                // rtc keeps running unless the whole system stops
                next_st.rtc_en  =
                    !next_st.sleep_cfg[pmcg_pkg::SLEEP_ALL_BIT]; // see [RULE5]
            end
            default:
            begin
                next_st.cpu_en  = 1'b0;
                next_st.peri_en = 8'h00;
                next_st.rtc_en  = 1'b0;
            end
        endcase

        // read mux, data shown the cycle after the strobe
        unique case (REG_ADDR_I)
            pmcg_pkg::ADDR_MODE_CTRL:
                rd = {4'h0, st.port_off, st.pll_en, 1'b0, st.slow_en};
            pmcg_pkg::ADDR_SLOW_DIV:  rd = {3'h0, st.div};
            pmcg_pkg::ADDR_SLEEP_CFG: rd = {2'h0, st.sleep_cfg};
            pmcg_pkg::ADDR_PERI_GATE: rd = st.gates;
            pmcg_pkg::ADDR_STATUS:    rd = {5'h00, st.mode};
            default:                  rd = 8'h00;
        endcase
        next_st.rdata = REG_RD_I ? rd : 8'h00;
    end

    // -----------------------------------------------------------------------
    // state register
    // -----------------------------------------------------------------------
    always_ff @(posedge SYS_CLK_I or negedge RESET_N_I)
    begin
        if (!RESET_N_I)
        begin
            st           <= '0;
            st.mode      <= pmcg_pkg::PMCG_RUN;
            st.slow_en   <= pmcg_pkg::RST_MODE_CTRL[pmcg_pkg::MODE_SLOW_BIT];
            st.pll_en    <= pmcg_pkg::RST_MODE_CTRL[pmcg_pkg::MODE_PLL_BIT];
            st.div       <= pmcg_pkg::RST_SLOW_DIV;
            st.sleep_cfg <= pmcg_pkg::RST_SLEEP_CFG;
            st.cpu_en    <= 1'b1;
            st.rtc_en    <= 1'b1;
        end
        else if (CLK_EN_I)
            st <= next_st;
    end

    // -----------------------------------------------------------------------
    // clock gates, one per clock; each has its own low-phase enable latch
    // -----------------------------------------------------------------------
    pmcg_clk_gate u_cpu_gate
    (
        .clk_i   (SYS_CLK_I),
        .rst_n_i (RESET_N_I),
        .en_i    (st.cpu_en & CLK_EN_I),
        .gclk_o  (CPU_CLK_O)
    ); // see [RULE9]

    pmcg_clk_gate u_rtc_gate
    (
        .clk_i   (SYS_CLK_I),
        .rst_n_i (RESET_N_I),
        .en_i    (st.rtc_en),
        .gclk_o  (RTC_CLK_O)
    );

    for (genvar g = 0; g < NPERI; g++)
    begin : g_peri
        pmcg_clk_gate u_gate
        (
            .clk_i   (SYS_CLK_I),
            .rst_n_i (RESET_N_I),
            .en_i    (st.peri_en[g]),
            .gclk_o  (PERI_CLK_O[g])
        ); // see [RULE8]
    end

    assign CPU_CLK_EN_O = st.cpu_en & CLK_EN_I;
    assign PLL_EN_O     = st.pll_en;
    assign PORT_EN_O    = !(st.mode == pmcg_pkg::PMCG_DOWN && st.port_off);
    assign MODE_O       = st.mode;
    assign REG_RDATA_O  = st.rdata;

    // -----------------------------------------------------------------------
    // assertions
    // -----------------------------------------------------------------------
    property p_down_sticky;
        @(posedge SYS_CLK_I) disable iff (!RESET_N_I)
        st.mode == pmcg_pkg::PMCG_DOWN |=> st.mode == pmcg_pkg::PMCG_DOWN;
    endproperty
    a_down_sticky: assert property (p_down_sticky) // see [RULE7]
        else $error("left full stop without reset");

    property p_down_clocks;
        @(posedge SYS_CLK_I) disable iff (!RESET_N_I)
        st.mode == pmcg_pkg::PMCG_DOWN |-> !st.cpu_en && st.peri_en == 8'h00;
    endproperty
    a_down_clocks: assert property (p_down_clocks) // see [RULE7]
        else $error("clock running in full stop");

    property p_idle_entry;
        @(posedge SYS_CLK_I) disable iff (!RESET_N_I)
        CLK_EN_I && IDLE_INSTR_I && !STOP_INSTR_I &&
        st.mode == pmcg_pkg::PMCG_RUN |=> st.mode == pmcg_pkg::PMCG_IDLE;
    endproperty
    a_idle_entry: assert property (p_idle_entry) // see [RULE2]
        else $error("idle instruction ignored");

    property p_idle_gates;
        @(posedge SYS_CLK_I) disable iff (!RESET_N_I)
        st.mode == pmcg_pkg::PMCG_IDLE |->
            st.peri_en == st.gates && !st.cpu_en;
    endproperty
    a_idle_gates: assert property (p_idle_gates) // see [RULE3]
        else $error("idle peripheral clocks wrong");

    property p_idle_exit;
        @(posedge SYS_CLK_I) disable iff (!RESET_N_I)
        CLK_EN_I && IRQ_I && st.mode == pmcg_pkg::PMCG_IDLE
        |=> st.mode != pmcg_pkg::PMCG_IDLE;
    endproperty
    a_idle_exit: assert property (p_idle_exit) // see [RULE4]
        else $error("interrupt did not end idle");

    property p_sleep_rtc;
        @(posedge SYS_CLK_I) disable iff (!RESET_N_I)
        st.mode == pmcg_pkg::PMCG_SLEEP |->
            st.rtc_en == !st.sleep_cfg[pmcg_pkg::SLEEP_ALL_BIT] && !st.cpu_en;
    endproperty
    a_sleep_rtc: assert property (p_sleep_rtc) // see [RULE5]
        else $error("sleep clock selection wrong");

    property p_sleep_wake;
        @(posedge SYS_CLK_I) disable iff (!RESET_N_I)
        CLK_EN_I && st.mode == pmcg_pkg::PMCG_SLEEP &&
        |(st.sync2 & st.sleep_cfg[5:1]) |=> st.mode != pmcg_pkg::PMCG_SLEEP;
    endproperty
    a_sleep_wake: assert property (p_sleep_wake) // see [RULE6]
        else $error("enabled wake source ignored");

    property p_slow_rate;
        @(posedge SYS_CLK_I) disable iff (!RESET_N_I)
        // a write in this cycle may end slow-down and raise the enable
        CLK_EN_I && !REG_WR_I && st.mode == pmcg_pkg::PMCG_SLOW && st.cpu_en &&
        st.div == 5'h01 && $stable(st.div) |=> !st.cpu_en;
    endproperty
    a_slow_rate: assert property (p_slow_rate) // see [RULE1]
        else $error("slow divider pulse too often");

    property p_gate_write;
        @(posedge SYS_CLK_I) disable iff (!RESET_N_I)
        CLK_EN_I && REG_WR_I && REG_ADDR_I == pmcg_pkg::ADDR_PERI_GATE
        |=> st.gates == $past(REG_WDATA_I);
    endproperty
    a_gate_write: assert property (p_gate_write) // see [RULE8]
        else $error("peripheral gate write lost");
endmodule : pmcg_top

//--- tb_pmcg_top.sv
`timescale 1ns/1ps
// ---------------------------------------------------------------------------
// compare helper: counts every check, reports and counts each mismatch
// ---------------------------------------------------------------------------
`define CHK(nm, exp, got) \
    begin \
        checked = checked + 1; \
        if ((got) !== (exp)) \
        begin \
            bad_count = bad_count + 1; \
            $display("MISMATCH %s expected %h seen %h", nm, exp, got); \
        end \
    end
module tb_pmcg_top;
    // -----------------------------------------------------------------------
    // stimulus and observed signals
    // -----------------------------------------------------------------------
    logic       sys_clk;     // 40 MHz source
    logic       reset_n;     // async reset, active low
    logic       clk_en;      // clock enable, low freezes state
    logic [3:0] reg_addr;    // register port address
    logic [7:0] reg_wdata;   // register port write data
    logic       reg_wr;      // write strobe
    logic       reg_rd;      // read strobe
    logic       idle_instr;  // idle instruction pulse
    logic       stop_instr;  // full stop instruction pulse
    logic       irq;         // any interrupt request
    logic [4:0] wake;        // ext, nmi, rtc, transfer, serial
    wire  [7:0] reg_rdata;   // read data, one cycle after the strobe
    wire        cpu_clk;     // gated cpu clock
    wire        cpu_clk_en;  // cpu advance enable
    wire  [7:0] peri_clk;    // gated peripheral clocks
    wire        rtc_clk;     // gated rtc clock
    wire        pll_en;      // pll switch
    wire        port_en;     // port drivers on
    wire  [2:0] mode;        // current power mode
    int         bad_count;   // mismatches seen
    int         checked;     // comparisons made
    int         cpu_hi;      // cycles with cpu clock high
    int         en_hi;       // cycles with cpu enable high
    int         rtc_hi;      // cycles with rtc clock high
    int         peri_hi [8]; // cycles with each peripheral clock high

    initial sys_clk = 1'b0;
    always #12.5 sys_clk = ~sys_clk;

    pmcg_top #(.NPERI(8)) u_pmcg_top (
        .SYS_CLK_I(sys_clk),       .RESET_N_I(reset_n),
        .CLK_EN_I(clk_en),         .REG_ADDR_I(reg_addr),
        .REG_WDATA_I(reg_wdata),   .REG_WR_I(reg_wr),
        .REG_RD_I(reg_rd),         .REG_RDATA_O(reg_rdata),
        .IDLE_INSTR_I(idle_instr), .STOP_INSTR_I(stop_instr),
        .IRQ_I(irq),               .EXT_IRQ_I(wake[0]),
        .NMI_I(wake[1]),           .RTC_EVT_I(wake[2]),
        .ETC_REQ_I(wake[3]),       .SER_ACT_I(wake[4]),
        .CPU_CLK_O(cpu_clk),       .CPU_CLK_EN_O(cpu_clk_en),
        .PERI_CLK_O(peri_clk),     .RTC_CLK_O(rtc_clk),
        .PLL_EN_O(pll_en),         .PORT_EN_O(port_en),
        .MODE_O(mode)
    );

    // -----------------------------------------------------------------------
    // glitch watch: the gated cpu clock may only move with the source clock
    // -----------------------------------------------------------------------
    always @(posedge cpu_clk) `CHK("cpu_rise", 1'b1, sys_clk)
    always @(negedge cpu_clk) `CHK("cpu_fall", 1'b0, sys_clk)

    // -----------------------------------------------------------------------
    // shared tasks
    // -----------------------------------------------------------------------
    task finish_test;
        if (bad_count == 0 && checked > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask : finish_test

    // reset asserted and released while the source is low, so the gate
    // latch clears without chopping a high phase
    task do_reset;
        @(negedge sys_clk) reset_n = 1'b0;
        repeat (4) @(posedge sys_clk);
        @(negedge sys_clk) reset_n = 1'b1;
    endtask : do_reset

    task reg_write(input logic [3:0] a, input logic [7:0] d);
        @(posedge sys_clk);
        reg_addr  <= a;
        reg_wdata <= d;
        reg_wr    <= 1'b1;
        @(posedge sys_clk);
        reg_wr    <= 1'b0;
    endtask : reg_write

    // read data stand only in the cycle after the strobe
    task reg_read(input logic [3:0] a, input logic [7:0] e, input string nm);
        @(posedge sys_clk);
        reg_addr <= a;
        reg_rd   <= 1'b1;
        @(posedge sys_clk);
        reg_rd   <= 1'b0;
        @(negedge sys_clk);
        `CHK(nm, e, reg_rdata)
    endtask : reg_read

    // one-cycle pulse on {irq, stop, idle}
    task pulse_in(input logic [2:0] sel);
        @(posedge sys_clk);
        {irq, stop_instr, idle_instr} <= sel;
        @(posedge sys_clk);
        {irq, stop_instr, idle_instr} <= 3'h0;
    endtask : pulse_in

    // async pins held long enough to pass the two-flop synchroniser
    task pulse_wake(input logic [4:0] w);
        @(posedge sys_clk);
        wake <= w;
        repeat (4) @(posedge sys_clk);
        wake <= 5'h00;
    endtask : pulse_wake

    // bounded wait for a mode, then one comparison
    task wait_mode(input logic [2:0] m, input int lim, input string nm);
        int i;
        i = 0;
        @(negedge sys_clk);
        while (mode !== m && i < lim)
        begin
            @(negedge sys_clk);
            i = i + 1;
        end
        `CHK(nm, m, mode)
    endtask : wait_mode

    // sample the gated clocks in the middle of each high phase
    task measure(input int n);
        cpu_hi = 0;
        en_hi  = 0;
        rtc_hi = 0;
        foreach (peri_hi[k]) peri_hi[k] = 0;
        repeat (n)
        begin
            @(posedge sys_clk);
            #5;
            cpu_hi = cpu_hi + int'(cpu_clk);
            en_hi  = en_hi + int'(cpu_clk_en);
            rtc_hi = rtc_hi + int'(rtc_clk);
            foreach (peri_hi[k]) peri_hi[k] = peri_hi[k] + int'(peri_clk[k]);
        end
    endtask : measure

    // -----------------------------------------------------------------------
    // scenarios
    // -----------------------------------------------------------------------
    task t_reset_regs;
        logic [7:0] gate_pat; // a set bit lets that peripheral clock run
        gate_pat = 8'hA5;
        @(negedge sys_clk);
        `CHK("mode", 3'h0, mode)
        `CHK("pll", 1'b1, pll_en)
        reg_read(pmcg_pkg::ADDR_MODE_CTRL, 8'h04, "mode_ctrl");
        reg_read(pmcg_pkg::ADDR_SLOW_DIV, 8'h00, "slow_div");
        reg_read(pmcg_pkg::ADDR_SLEEP_CFG, 8'h3E, "sleep_cfg");
        reg_read(pmcg_pkg::ADDR_PERI_GATE, 8'h00, "gates");
        reg_write(pmcg_pkg::ADDR_STATUS, 8'hFF);
        reg_read(pmcg_pkg::ADDR_STATUS, 8'h00, "status");
        reg_read(4'hF, 8'h00, "unmapped");
        // gate bits are enables: only the set bits clock in running mode
        reg_write(pmcg_pkg::ADDR_PERI_GATE, gate_pat);
        measure(16);
        foreach (peri_hi[k])
            `CHK("peri_run", gate_pat[k] ? 16 : 0, peri_hi[k])
        reg_write(pmcg_pkg::ADDR_MODE_CTRL, 8'h00);
        @(negedge sys_clk);
        `CHK("pll_off", 1'b0, pll_en)
        reg_write(pmcg_pkg::ADDR_MODE_CTRL, 8'h04);
        @(negedge sys_clk);
        `CHK("pll_on", 1'b1, pll_en)
    endtask : t_reset_regs

    // both ends of the divider range, and divide by 2 in between
    task t_slow;
        logic [7:0] dv [3];
        dv[0] = 8'h00;
        dv[1] = 8'h01;
        dv[2] = 8'h1F;
        foreach (dv[j])
        begin
            reg_write(pmcg_pkg::ADDR_SLOW_DIV, dv[j]);
            reg_read(pmcg_pkg::ADDR_SLOW_DIV, dv[j], "div_rb");
            reg_write(pmcg_pkg::ADDR_MODE_CTRL, 8'h05);
            wait_mode(pmcg_pkg::PMCG_SLOW, 2, "slow_mode");
            measure(64);
            `CHK("slow_en", 64 / (int'(dv[j]) + 1), en_hi)
            `CHK("slow_clk", 64 / (int'(dv[j]) + 1), cpu_hi)
            reg_write(pmcg_pkg::ADDR_MODE_CTRL, 8'h04);
            wait_mode(pmcg_pkg::PMCG_RUN, 2, "slow_exit");
        end
    endtask : t_slow

    // enabled lower half keeps running in idle, switched-off upper half not
    task t_idle;
        reg_write(pmcg_pkg::ADDR_PERI_GATE, 8'h0F);
        pulse_in(3'b001);
        wait_mode(pmcg_pkg::PMCG_IDLE, 0, "idle_in");
        `CHK("idle_en", 1'b0, cpu_clk_en)
        measure(16);
        `CHK("idle_cpu", 0, cpu_hi)
        foreach (peri_hi[k])
            `CHK("idle_peri", (k < 4) ? 16 : 0, peri_hi[k])
        pulse_in(3'b100);
        wait_mode(pmcg_pkg::PMCG_RUN, 0, "idle_out");
        `CHK("run_en", 1'b1, cpu_clk_en)
        reg_write(pmcg_pkg::ADDR_PERI_GATE, 8'h00);
    endtask : t_idle

    // an idle instruction while the clock enable is low must be lost
    task t_freeze;
        @(posedge sys_clk);
        clk_en <= 1'b0;
        pulse_in(3'b001);
        @(negedge sys_clk);
        `CHK("frz_mode", 3'h0, mode)
        `CHK("frz_en", 1'b0, cpu_clk_en)
        @(posedge sys_clk);
        clk_en <= 1'b1;
    endtask : t_freeze

    task t_sleep;
        reg_write(pmcg_pkg::ADDR_SLEEP_CFG, 8'h02);
        reg_write(pmcg_pkg::ADDR_MODE_CTRL, 8'h06);
        wait_mode(pmcg_pkg::PMCG_SLEEP, 2, "sleep_in");
        measure(16);
        `CHK("sleep_rtc", 16, rtc_hi)
        `CHK("sleep_cpu", 0, cpu_hi)
        `CHK("sleep_peri", 0, peri_hi[7])
        pulse_wake(5'h02);
        repeat (4) @(posedge sys_clk);
        wait_mode(pmcg_pkg::PMCG_SLEEP, 0, "nmi_masked");
        pulse_wake(5'h01);
        wait_mode(pmcg_pkg::PMCG_RUN, 6, "ext_wake");
        // whole clock system stopped, every wake source tried in turn
        reg_write(pmcg_pkg::ADDR_SLEEP_CFG, 8'h3F);
        for (int i = 0; i < 5; i++)
        begin
            reg_write(pmcg_pkg::ADDR_MODE_CTRL, 8'h06);
            wait_mode(pmcg_pkg::PMCG_SLEEP, 2, "sleep_all");
            measure(8);
            `CHK("all_rtc", 0, rtc_hi)
            pulse_wake(5'(1 << i));
            wait_mode(pmcg_pkg::PMCG_RUN, 6, "src_wake");
        end
    endtask : t_sleep

    // only a reset leaves full stop
    task t_stop;
        reg_write(pmcg_pkg::ADDR_MODE_CTRL, 8'h0C);
        pulse_in(3'b010);
        wait_mode(pmcg_pkg::PMCG_DOWN, 0, "stop_in");
        `CHK("stop_port", 1'b0, port_en)
        pulse_in(3'b100);
        pulse_wake(5'h1F);
        measure(16);
        `CHK("stop_cpu", 0, cpu_hi)
        foreach (peri_hi[k]) `CHK("stop_peri", 0, peri_hi[k])
        wait_mode(pmcg_pkg::PMCG_DOWN, 0, "stop_hold");
        do_reset();
        wait_mode(pmcg_pkg::PMCG_RUN, 0, "stop_reset");
        `CHK("port_back", 1'b1, port_en)
    endtask : t_stop

    // -----------------------------------------------------------------------
    // main sequence and watchdog
    // -----------------------------------------------------------------------
    initial
    begin
        bad_count  = 0;
        checked    = 0;
        reset_n    = 1'b0;
        clk_en     = 1'b1;
        reg_addr   = 4'h0;
        reg_wdata  = 8'h00;
        reg_wr     = 1'b0;
        reg_rd     = 1'b0;
        idle_instr = 1'b0;
        stop_instr = 1'b0;
        irq        = 1'b0;
        wake       = 5'h00;
        repeat (4) @(posedge sys_clk);
        @(negedge sys_clk) reset_n = 1'b1;
        t_reset_regs();
        t_slow();
        t_idle();
        t_freeze();
        t_sleep();
        t_stop();
        finish_test();
    end

    // whole run needs well under 2000 cycles
    initial
    begin
        repeat (6000) @(posedge sys_clk);
        bad_count = bad_count + 1;
        finish_test();
    end
endmodule : tb_pmcg_top
